// ===== src/scpc_top.v
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scpc_regs.vh"
module scpc_top #(
   parameter MS_CYCLES = `SCPC_MS_NS / `SCPC_CLK_NS,
   parameter NUM_PATHS = 8,
   // Identity values below are arbitrary.
   parameter [31:0] UNIT_SERIAL = 32'h0000_1001,
   parameter [31:0] BARE_SERIAL = 32'h0000_2002,
   parameter [31:0] PLUG_SERIAL = 32'h0000_3003,
   parameter [63:0] UNIT_PART = "UNIT0001",
   parameter [63:0] BARE_PART = "BARE0001",
   parameter [63:0] PLUG_PART = "PLUG0001",
   parameter [63:0] FW_VERSION = "V1.00.00",
   parameter [63:0] LOADED_LEVEL = "CFG01.00",
   parameter [63:0] SUPPORTED_LEVEL = "CFG02.00"
) (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SCPC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Health from the scanner core
   input wire [7:0] device_state,
   input wire [15:0] user_action_in,
   // Monitoring case selection
   output reg case_switch_enable,
   output reg [7:0] case_inputs,
   output reg [7:0] active_case,
   output reg active_case_valid,
   // Commands
   output wire [7:0] path_interlock_reset_pulse,
   output wire safety_restart_pulse,
   output wire partial_reboot_pulse,
   output wire full_reboot_pulse,
   output reg standby_request
);
   // Levels and case data as last written over the bus.
   reg one_of_n_mode;
   reg restart_level;
   reg partial_level;
   reg full_level;
   reg [7:0] case_number;
   reg [7:0] path_level;

   // Health attributes and registered case checks.
   reg [7:0] status_code;
   reg [15:0] user_action_hints;
   reg inputs_ok_q;
   reg number_ok_q;

   // Read decode for the coming access phase.
   reg [31:0] next_rdata;
   reg next_err;
   reg next_ro;

   // Timebase, evaluation results and read words.
   wire ms_tick;
   wire [3:0] pair_ok;
   wire one_hot;
   wire inputs_ok;
   wire number_ok;
   wire wr_commit;
   wire [31:0] ctrl_word;
   wire [31:0] case_word;
   wire [31:0] case_status;
   wire [7:0] path_present;
   wire case_accept;
   wire setup_phase;
   wire status_known;

   // One shared millisecond tick drives every qualifier.
   scpc_ms_tick #(
      .MS_CYCLES(MS_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick)
   );

   // Each reset trigger gets its own qualifier; absent paths never fire.
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_path
         scpc_pulse_qual #(
            .MIN_MS(`SCPC_PATH_MIN_MS),
            .FIRE_ON_FALL(0)
         ) u_path (
            .pclk(pclk),
            .presetn(presetn),
            .level(path_level[i] & path_present[i]), // R10
            .ms_tick(ms_tick),
            .fire(path_interlock_reset_pulse[i]) // R9
         );
      end
      for (i = 0; i < 8; i = i + 1) begin : g_present
         // Paths beyond the variant's count stay tied off.
         assign path_present[i] = (i < NUM_PATHS) ? 1'b1 : 1'b0; // R10
      end
      for (i = 0; i < 4; i = i + 1) begin : g_pair
         // Complementary pair check on inputs 2i and 2i+1.
         assign pair_ok[i] = case_inputs[2*i] ^ case_inputs[2*i+1]; // R7
      end
   endgenerate

   // Commands act when the pulse ends, so a held level never fires.
   scpc_pulse_qual #(
      .MIN_MS(`SCPC_CMD_MIN_MS),
      .FIRE_ON_FALL(1)
   ) u_restart (
      .pclk(pclk),
      .presetn(presetn),
      .level(restart_level),
      .ms_tick(ms_tick),
      .fire(safety_restart_pulse) // R11
   );

   scpc_pulse_qual #(
      .MIN_MS(`SCPC_CMD_MIN_MS),
      .FIRE_ON_FALL(1)
   ) u_partial (
      .pclk(pclk),
      .presetn(presetn),
      .level(partial_level),
      .ms_tick(ms_tick),
      .fire(partial_reboot_pulse) // R13
   );

   scpc_pulse_qual #(
      .MIN_MS(`SCPC_CMD_MIN_MS),
      .FIRE_ON_FALL(1)
   ) u_full (
      .pclk(pclk),
      .presetn(presetn),
      .level(full_level),
      .ms_tick(ms_tick),
      .fire(full_reboot_pulse) // R14
   );

   // Clearing the lowest set bit must leave nothing for one-of-n.
   assign one_hot = (case_inputs != 8'h00) &&
      ((case_inputs & (case_inputs - 8'h01)) == 8'h00); // R7
   assign inputs_ok = one_of_n_mode ? one_hot : (&pair_ok); // R7
   assign number_ok = (case_number >= `SCPC_CASE_NUM_MIN) &&
      (case_number <= `SCPC_CASE_NUM_MAX); // R8
   // An error answer blocks the write, so a refused access leaves no trace.
   assign wr_commit = psel && penable && pready && pwrite && !pslverr;
   assign setup_phase = psel && !penable;
   // A switch needs the enable, valid inputs and a valid number at once.
   assign case_accept = case_switch_enable && inputs_ok && number_ok;
   assign status_known = device_state <= `SCPC_ST_SERIOUS;

   assign ctrl_word = {26'h000_0000, one_of_n_mode, full_level,
      partial_level, restart_level, standby_request, case_switch_enable};
   assign case_word = {16'h0000, case_number, case_inputs};
   // The check results are shown one cycle late, from registers.
   assign case_status = {21'h00_0000, active_case_valid, number_ok_q,
      inputs_ok_q, active_case};

   // Read data and error are decoded in the setup cycle.
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      next_ro = 1'b1;
      case (paddr)
         `SCPC_A_CTRL: begin
            next_rdata = ctrl_word;
            next_ro = 1'b0;
         end
         `SCPC_A_CASE: begin
            next_rdata = case_word;
            next_ro = 1'b0;
         end
         `SCPC_A_PATH: begin
            next_rdata = {24'h00_0000, path_level};
            next_ro = 1'b0;
         end
         `SCPC_A_STATUS: next_rdata = {24'h00_0000, status_code}; // R1
         `SCPC_A_HINTS: next_rdata = {16'h0000, user_action_hints}; // R2
         `SCPC_A_CASE_ST: next_rdata = case_status;
         `SCPC_A_SER_UNIT: next_rdata = UNIT_SERIAL; // R3
         `SCPC_A_SER_BARE: next_rdata = BARE_SERIAL; // R3
         `SCPC_A_SER_PLUG: next_rdata = PLUG_SERIAL; // R3
         `SCPC_A_STR_BASE: next_rdata = UNIT_PART[31:0]; // R3
         `SCPC_A_UNIT_HI: next_rdata = UNIT_PART[63:32]; // R3
         `SCPC_A_BARE_LO: next_rdata = BARE_PART[31:0]; // R3
         `SCPC_A_BARE_HI: next_rdata = BARE_PART[63:32]; // R3
         `SCPC_A_PLUG_LO: next_rdata = PLUG_PART[31:0]; // R3
         `SCPC_A_PLUG_HI: next_rdata = PLUG_PART[63:32]; // R3
         `SCPC_A_FW_LO: next_rdata = FW_VERSION[31:0]; // R4
         `SCPC_A_FW_HI: next_rdata = FW_VERSION[63:32]; // R4
         `SCPC_A_LOAD_LO: next_rdata = LOADED_LEVEL[31:0]; // R5
         `SCPC_A_LOAD_HI: next_rdata = LOADED_LEVEL[63:32]; // R5
         `SCPC_A_SUPP_LO: next_rdata = SUPPORTED_LEVEL[31:0]; // R5
         `SCPC_A_STR_LAST: next_rdata = SUPPORTED_LEVEL[63:32]; // R5
         default: begin
            next_err = 1'b1;
            next_ro = 1'b0;
         end
      endcase
      if (pwrite && next_ro) begin
         next_err = 1'b1;
      end
      // Writes always return zero read data.
      if (pwrite) begin
         next_rdata = 32'h0000_0000;
      end
   end

   // APB answer: one wait-free access phase after every setup cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup_phase) begin
         pready <= 1'b1;
         pslverr <= next_err;
         prdata <= next_rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // Process data written by the controller.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         case_switch_enable <= 1'b0;
         standby_request <= 1'b0;
         restart_level <= 1'b0;
         partial_level <= 1'b0;
         full_level <= 1'b0;
         one_of_n_mode <= 1'b0;
         case_inputs <= 8'h00;
         case_number <= 8'h00;
         path_level <= 8'h00;
      end else if (wr_commit) begin
         case (paddr)
            `SCPC_A_CTRL: begin
               case_switch_enable <= pwdata[`SCPC_CTRL_CASE_EN]; // R6
               standby_request <= pwdata[`SCPC_CTRL_STANDBY]; // R12
               restart_level <= pwdata[`SCPC_CTRL_RESTART];
               partial_level <= pwdata[`SCPC_CTRL_PARTIAL];
               full_level <= pwdata[`SCPC_CTRL_FULL];
               one_of_n_mode <= pwdata[`SCPC_CTRL_ONE_OF_N];
            end
            `SCPC_A_CASE: begin
               case_inputs <= pwdata[7:0]; // R7
               case_number <= pwdata[`SCPC_CASE_NUM_LSB+7:
                  `SCPC_CASE_NUM_LSB];
            end
            `SCPC_A_PATH: begin
               // Absent paths drop their bits and read back as zero.
               path_level <= pwdata[7:0] & path_present; // R10
            end
            default: begin
               path_level <= path_level;
            end
         endcase
      end
   end

   // Case changes only while enabled and only from valid signals.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_case <= 8'h00;
         active_case_valid <= 1'b0;
         inputs_ok_q <= 1'b0;
         number_ok_q <= 1'b0;
      end else begin
         inputs_ok_q <= inputs_ok;
         number_ok_q <= number_ok;
         if (case_accept) begin
            active_case <= case_number; // R6 R8
            active_case_valid <= 1'b1;
         end
      end
   end

   // Health attributes; codes above the defined range read as unclear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_code <= `SCPC_ST_UNCLEAR;
         user_action_hints <= 16'h0000;
      end else begin
         if (!status_known) begin
            status_code <= `SCPC_ST_UNCLEAR; // R1
         end else begin
            status_code <= device_state; // R1
         end
         // Only the low hint bits carry actions; the rest read as zero.
         user_action_hints <= {8'h00,
            user_action_in[`SCPC_HINT_USED-1:0]}; // R2
      end
   end
endmodule // scpc_top
`default_nettype wire

// ===== src/scpc_regs.vh
// What this block does
// R1 - Report device status as code 0 to 8
// R2 - Expose 16-bit hint word, bits 0-7 used
// R3 - Read-only serials and part numbers, three units
// R4 - Read-only firmware version string
// R5 - Loaded and supported feature level strings
// R6 - Case switching only while enable bit set
// R7 - Eight control inputs, pair or one-of-n check
// R8 - Case number zero invalid, 1 to 254 select
// R9 - Path reset needs 60 ms high pulse
// R10 - Reset triggers for paths 1 to 8
// R11 - Safety restart on 120 ms pulse, held ignored
// R12 - Standby while standby bit is one
// R13 - Partial reboot on 120 ms pulse
// R14 - Full reboot on 120 ms pulse
// R15 - Millisecond high-time count, rearm after low
`ifndef SCPC_REGS_VH
`define SCPC_REGS_VH

`define SCPC_ADDR_W 8
`define SCPC_A_CTRL 8'h00
`define SCPC_A_CASE 8'h04
`define SCPC_A_PATH 8'h08
`define SCPC_A_STATUS 8'h0C
`define SCPC_A_HINTS 8'h10
`define SCPC_A_CASE_ST 8'h14
`define SCPC_A_SER_UNIT 8'h18
`define SCPC_A_SER_BARE 8'h1C
`define SCPC_A_SER_PLUG 8'h20
`define SCPC_A_STR_BASE 8'h40
`define SCPC_A_UNIT_HI 8'h44
`define SCPC_A_BARE_LO 8'h48
`define SCPC_A_BARE_HI 8'h4C
`define SCPC_A_PLUG_LO 8'h50
`define SCPC_A_PLUG_HI 8'h54
`define SCPC_A_FW_LO 8'h58
`define SCPC_A_FW_HI 8'h5C
`define SCPC_A_LOAD_LO 8'h60
`define SCPC_A_LOAD_HI 8'h64
`define SCPC_A_SUPP_LO 8'h68
`define SCPC_A_STR_LAST 8'h6C

`define SCPC_CTRL_CASE_EN 0
`define SCPC_CTRL_STANDBY 1
`define SCPC_CTRL_RESTART 2
`define SCPC_CTRL_PARTIAL 3
`define SCPC_CTRL_FULL 4
`define SCPC_CTRL_ONE_OF_N 5
`define SCPC_CASE_NUM_LSB 8

`define SCPC_ST_UNCLEAR 8'h00
`define SCPC_ST_SERIOUS 8'h08
`define SCPC_HINT_USED 8
`define SCPC_CASE_NUM_MIN 8'h01
`define SCPC_CASE_NUM_MAX 8'hFE

`define SCPC_MS_NS 1000000
`define SCPC_CLK_NS 10
`define SCPC_PATH_MIN_MS 60
`define SCPC_CMD_MIN_MS 120
`define SCPC_QUAL_W 8

`endif

// ===== src/scpc_ms_tick.v
`timescale 1ns/1ps
`default_nettype none
module scpc_ms_tick #(
   parameter MS_CYCLES = 100000
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Timebase
   output reg ms_tick
);
   reg [31:0] count;

   // One-cycle tick every MS_CYCLES clocks.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end else if (count == MS_CYCLES[31:0] - 32'h0000_0001) begin
         count <= 32'h0000_0000;
         ms_tick <= 1'b1; // R15
      end else begin
         count <= count + 32'h0000_0001;
         ms_tick <= 1'b0;
      end
   end
endmodule // scpc_ms_tick
`default_nettype wire

// ===== src/scpc_pulse_qual.v
`timescale 1ns/1ps
`default_nettype none
module scpc_pulse_qual #(
   parameter [7:0] MIN_MS = 8'd60,
   parameter FIRE_ON_FALL = 0
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Trigger level and timebase
   input wire level,
   input wire ms_tick,
   // Qualified event
   output reg fire
);
   reg level_q;
   reg [7:0] high_ms;
   wire [7:0] need;

   // One extra tick guards against a tick landing just after the rise.
   assign need = MIN_MS + 8'h01;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 1'b0;
         high_ms <= 8'h00;
         fire <= 1'b0;
      end else begin
         level_q <= level;
         fire <= 1'b0;
         if (!level) begin
            high_ms <= 8'h00; // R15
         end else if (ms_tick && high_ms != need) begin
            high_ms <= high_ms + 8'h01; // R15
         end
         if (FIRE_ON_FALL != 0) begin
            // Fire only when the pulse ends, so a held high never acts.
            if (level_q && !level && high_ms == need) begin
               fire <= 1'b1; // R11 R13 R14
            end
         end else if (level && ms_tick && high_ms == need - 8'h01) begin
            fire <= 1'b1; // R9
         end
      end
   end
endmodule // scpc_pulse_qual
`default_nettype wire

// ===== tb/scpc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "scpc_regs.vh"
module scpc_props (
   // Clock, reset and bus
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SCPC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   // Controls and events
   input wire case_switch_enable,
   input wire [7:0] active_case,
   input wire standby_request,
   input wire safety_restart_pulse,
   input wire partial_reboot_pulse,
   input wire full_reboot_pulse
);
   wire wr_ctrl = psel & penable & pready & pwrite & ~pslverr
      & (paddr == `SCPC_A_CTRL);
   wire [2:0] clr = {3{wr_ctrl}} & ~pwdata[4:2];
   wire [2:0] cmd = {full_reboot_pulse, partial_reboot_pulse,
      safety_restart_pulse};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_case_needs_enable: assert property (
      $changed(active_case) |-> $past(case_switch_enable))
      else $error("case changed while disabled");
   a_case_num_range: assert property (
      $changed(active_case) |-> active_case inside {[1:254]})
      else $error("invalid case number taken");
   a_standby_follows: assert property (
      wr_ctrl |=> standby_request == $past(pwdata[1]))
      else $error("standby does not follow write");
   a_restart_after_fall: assert property (
      cmd[0] |-> $past(clr[0], 2) || $past(clr[0], 3))
      else $error("restart pulse without release");
   a_partial_after_fall: assert property (
      cmd[1] |-> $past(clr[1], 2) || $past(clr[1], 3))
      else $error("partial reboot without release");
   a_full_after_fall: assert property (
      cmd[2] |-> $past(clr[2], 2) || $past(clr[2], 3))
      else $error("full reboot without release");
endmodule // scpc_props
bind scpc_top scpc_props scpc_props_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .case_switch_enable,
   .active_case, .standby_request, .safety_restart_pulse,
   .partial_reboot_pulse, .full_reboot_pulse);
`default_nettype wire

// ===== tb/scpc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scpc_ctrl_model (
   // Clock
   input wire pclk,
   // Request
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0000_0000,
   // Answer
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   // One bus transfer; the request stands until ready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // scpc_ctrl_model
`default_nettype wire

// ===== tb/scpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scpc_top_tb;
   localparam logic [63:0] STR [3] = '{"FW-7.3.1", "LVL-0004", "LVL-0009"};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] device_state = 8'h00;
   logic [15:0] user_action_in = 16'h0000;
   wire psel, penable, pwrite, pready, pslverr, cse, acv, sby;
   wire [7:0] paddr, cin, act, pth;
   wire [31:0] pwdata, prdata;
   wire [2:0] cmd;
   int bad_count = 0;
   int compares = 0;
   int pc [8] = '{default: 0};
   int cc [3] = '{default: 0};
   always #5 pclk = ~pclk;
   scpc_ctrl_model scpc_ctrl_model_i (.pclk, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr);
   scpc_top #(.MS_CYCLES(10), .UNIT_SERIAL(32'h5A5A_0017),
      .FW_VERSION(STR[0]), .LOADED_LEVEL(STR[1]),
      .SUPPORTED_LEVEL(STR[2])) scpc_top_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .device_state, .user_action_in, .case_switch_enable(cse),
      .case_inputs(cin), .active_case(act), .active_case_valid(acv),
      .path_interlock_reset_pulse(pth), .safety_restart_pulse(cmd[0]),
      .partial_reboot_pulse(cmd[1]), .full_reboot_pulse(cmd[2]),
      .standby_request(sby));
   always @(posedge pclk) begin
      for (int i = 0; i < 8; i++) pc[i] += pth[i];
      for (int i = 0; i < 3; i++) cc[i] += cmd[i];
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      scpc_ctrl_model_i.xfer(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] r;
      logic e;
      scpc_ctrl_model_i.xfer(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wr_ro(input logic [7:0] a);
      logic [31:0] r;
      logic e;
      scpc_ctrl_model_i.xfer(1'b1, a, 32'hFFFF_FFFF, r, e);
      chk(r, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
   endtask
   task automatic ms(input int n);
      repeat (n * 10) @(posedge pclk);
   endtask
   task automatic stop_test;
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0000_0000, 1'b0);
      for (int k = 0; k < 10; k++) begin
         device_state <= 8'(k);
         repeat (2) @(posedge pclk);
         rd(8'h10 - 8'h04, 32'(k <= 8 ? k : 0), 1'b0);
      end
      user_action_in <= 16'hA5C3;
      repeat (2) @(posedge pclk);
      rd(8'h10, 32'h0000_00C3, 1'b0);
      wr_ro(8'h0C);
      rd(8'h0C, 32'h0000_0000, 1'b0);
      rd(8'h30, 32'h0000_0000, 1'b1);
      rd(8'h18, 32'h5A5A_0017, 1'b0);
      for (int i = 0; i < 3; i++) begin
         rd(8'(8'h58 + 8 * i), STR[i][31:0], 1'b0);
         rd(8'(8'h5C + 8 * i), STR[i][63:32], 1'b0);
      end
      wr(8'h04, 32'h0000_0555);
      rd(8'h14, 32'h0000_0300, 1'b0);
      chk({22'h00_0000, cse, acv, cin}, 32'h0000_0055);
      wr(8'h00, 32'h0000_0001);
      rd(8'h14, 32'h0000_0705, 1'b0);
      chk({22'h00_0000, cse, acv, cin}, 32'h0000_0355);
      wr(8'h04, 32'h0000_0055);
      rd(8'h14, 32'h0000_0505, 1'b0);
      wr(8'h04, 32'h0000_0703);
      rd(8'h14, 32'h0000_0605, 1'b0);
      wr(8'h00, 32'h0000_0021);
      wr(8'h04, 32'h0000_0908);
      rd(8'h14, 32'h0000_0709, 1'b0);
      wr(8'h04, 32'h0000_FF08);
      rd(8'h14, 32'h0000_0509, 1'b0);
      wr(8'h00, 32'h0000_0020);
      wr(8'h04, 32'h0000_0A08);
      rd(8'h14, 32'h0000_0709, 1'b0);
      chk({24'h0, act}, 32'h0000_0009);
      wr(8'h00, 32'h0000_0002);
      @(posedge pclk);
      chk({31'h0, sby}, 32'h0000_0001);
      wr(8'h00, 32'h0000_0000);
      @(posedge pclk);
      chk({31'h0, sby}, 32'h0000_0000);
      wr(8'h08, 32'h0000_00FF);
      ms(63);
      wr(8'h08, 32'h0000_0000);
      for (int i = 0; i < 8; i++) chk(32'(pc[i]), 32'h0000_0001);
      wr(8'h08, 32'h0000_0002);
      ms(55);
      wr(8'h08, 32'h0000_0000);
      ms(2);
      chk(32'(pc[1]), 32'h0000_0001);
      for (int b = 0; b < 3; b++) begin
         wr(8'h00, 32'(1 << (b + 2)));
         ms(125);
         wr(8'h00, 32'h0000_0000);
         ms(1);
         chk(32'(cc[b]), 32'h0000_0001);
         wr(8'h00, 32'(1 << (b + 2)));
         ms(100);
         wr(8'h00, 32'h0000_0000);
         ms(1);
         chk(32'(cc[b]), 32'h0000_0001);
         wr(8'h00, 32'(1 << (b + 2)));
         ms(130);
         chk(32'(cc[b]), 32'h0000_0001);
         wr(8'h00, 32'h0000_0000);
         ms(1);
         chk(32'(cc[b]), 32'h0000_0002);
      end
      stop_test();
   end
endmodule // scpc_top_tb
`default_nettype wire
